//--- pkg/nbh_pkg.sv
// Shared constants, types and helpers of the NAND bus host controller.
package nbh_pkg;

    localparam int CLK_PERIOD_NS = 4;
    localparam int T_SETUP_NS    = 10;
    localparam int T_WP_NS       = 10;
    localparam int T_WH_NS       = 10;
    localparam int T_WB_NS       = 100;

    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_CYC  = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WB_CYC    = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] SETUP_LD = 8'(SETUP_CYC - 1);
    localparam logic [7:0] LOW_LD   = 8'(LOW_CYC - 1);
    localparam logic [7:0] HIGH_LD  = 8'(HIGH_CYC - 1);
    localparam logic [7:0] WB_LD    = 8'(WB_CYC - 1);

    localparam logic [7:0] CMD_STATUS              = 8'h70;
    localparam logic [7:0] PER_DIE_STATUS_READ_CMD = 8'h78;

    localparam int IO_W       = 16;
    localparam int COL_W      = 12;
    localparam int PAGE_W     = 6;
    localparam int BLK_W      = 11;
    localparam int ROW_W      = PAGE_W + BLK_W;
    localparam int NDATA_W    = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int COL_TOP    = 11;
    localparam int COL_CLR_HI = 10;
    localparam int COL_CLR_LO = 7;
    localparam int PLANE_BIT  = 0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_DATA  = 3'b011,
        ST_CMD2  = 3'b100,
        ST_FIN   = 3'b101,
        ST_WAITB = 3'b110
    } nbh_state_t;

    typedef enum logic [1:0] {
        PH_SETUP = 2'b00,
        PH_LOW   = 2'b01,
        PH_HIGH  = 2'b10
    } nbh_phase_t;

    function automatic logic is_status(input logic [7:0] cmd);
        return (cmd == CMD_STATUS) || (cmd == PER_DIE_STATUS_READ_CMD);
    endfunction

    function automatic logic [7:0] addr_byte(input logic [2:0]        idx,
                                             input logic [COL_W-1:0]  col,
                                             input logic [PAGE_W-1:0] page,
                                             input logic [BLK_W-1:0]  blk);
        logic [COL_W-1:0] c;
        logic [ROW_W-1:0] row;
        c   = col;
        row = {blk, page};
        if (c[COL_TOP]) begin
            c[COL_CLR_HI:COL_CLR_LO] = '0;
        end
        case (idx)
            3'h0:    return c[7:0];
            3'h1:    return {4'h0, c[11:8]};
            3'h2:    return row[7:0];
            3'h3:    return row[15:8];
            3'h4:    return {7'h00, row[16]};
            default: return 8'h00;
        endcase
    endfunction

    function automatic nbh_state_t pick(input logic has_addr,
                                        input logic has_data,
                                        input logic has_cmd2);
        if (has_addr) begin
            return ST_ADDR;
        end
        if (has_data) begin
            return ST_DATA;
        end
        return has_cmd2 ? ST_CMD2 : ST_FIN;
    endfunction

endpackage

//--- verilog/nbh_fifo.sv
// Write data FIFO with a registered output stage.
`timescale 1ns/1ns
module nbh_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    // Pointers wrap naturally, so DEPTH must be a power of two.
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    in_ready;
        logic                    out_valid;
        logic [W-1:0]            out_data;
    } nbh_fifo_state_t;

    nbh_fifo_state_t r;
    nbh_fifo_state_t next_r;
    logic            push;
    logic            pop_out;
    logic            load;

    always_comb begin
        next_r  = r;
        push    = in_valid_i && r.in_ready;
        pop_out = r.out_valid && out_ready_i;
        load    = (!r.out_valid || pop_out) && (r.cnt != '0);
        if (push) begin
            next_r.mem[r.wp] = in_data_i;
            next_r.wp        = r.wp + AW'(1);
        end
        if (load) begin
            next_r.out_data  = r.mem[r.rp];
            next_r.rp        = r.rp + AW'(1);
            next_r.out_valid = 1'b1;
        end else if (pop_out) begin
            next_r.out_valid = 1'b0;
        end
        next_r.cnt      = r.cnt + (AW+1)'(push) - (AW+1)'(load);
        next_r.in_ready = next_r.cnt != (AW+1)'(DEPTH);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r          <= '0;
            r.in_ready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign in_ready_o  = r.in_ready;
    assign out_valid_o = r.out_valid;
    assign out_data_o  = r.out_data;
endmodule

//--- verilog/nbh_host.sv
// Host controller that drives the multiplexed asynchronous NAND bus.
// What this block does
// - Command, address and data share the I/O lines; latch controls tell them apart.
// - Commands and address bytes go on the low byte; upper byte carries data only.
// - Host drives the upper I/O byte to zero in command and address cycles.
// - A sequence is one command, its address cycles, data cycles, then an optional second command.
// - Host drives address bits outside the implemented space low.
// - Address goes out in req_naddr_i cycles: column low, column high, row bytes.
// - When column bit 11 is set, column bits 10 to 7 are sent cleared.
`timescale 1ns/1ns
module nbh_host
    import nbh_pkg::*;
#(
    parameter bit WIDE  = 1'b1,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    input  wire logic               req_valid_i,
    output logic                    req_ready_o,
    input  wire logic [7:0]         req_cmd_i,
    input  wire logic [2:0]         req_naddr_i,
    input  wire logic [COL_W-1:0]   req_col_i,
    input  wire logic [PAGE_W-1:0]  req_page_i,
    input  wire logic [BLK_W-1:0]   req_block_i,
    input  wire logic               req_write_i,
    input  wire logic [NDATA_W-1:0] req_ndata_i,
    input  wire logic               req_cmd2_en_i,
    input  wire logic [7:0]         req_cmd2_i,
    input  wire logic               req_wait_i,
    input  wire logic               wr_valid_i,
    input  wire logic [IO_W-1:0]    wr_data_i,
    output logic                    wr_ready_o,
    output logic                    rd_valid_o,
    output logic [IO_W-1:0]         rd_data_o,
    output logic                    done_o,
    output logic                    busy_o,
    input  wire logic               wp_en_i,
    output logic                    ce_n_o,
    output logic                    cle_o,
    output logic                    ale_o,
    output logic                    we_n_o,
    output logic                    read_strobe_n_o,
    output logic                    wp_n_o,
    output logic [IO_W-1:0]         io_o,
    output logic                    io_oe_o,
    input  wire logic [IO_W-1:0]    io_i,
    input  wire logic               rb_n_i
);
    typedef struct packed {
        nbh_state_t          st;
        nbh_phase_t          ph;
        logic [7:0]          cnt;
        logic [2:0]          aidx;
        logic [NDATA_W-1:0]  dcnt;
        logic [7:0]          cmd;
        logic [2:0]          naddr;
        logic [COL_W-1:0]    col;
        logic [PAGE_W-1:0]   page;
        logic [BLK_W-1:0]    blk;
        logic                wr;
        logic [NDATA_W-1:0]  ndata;
        logic                cmd2_en;
        logic [7:0]          cmd2;
        logic                waitr;
        logic                req_ready;
        logic                done;
        logic                busy;
        logic                ce_n;
        logic                cle;
        logic                ale;
        logic                we_n;
        logic                re_n;
        logic                oe;
        logic                wp_n;
        logic [IO_W-1:0]     io;
        logic                rd_valid;
        logic [IO_W-1:0]     rd_data;
    } nbh_host_state_t;

    nbh_host_state_t r;
    nbh_host_state_t next_r;
    logic            fifo_valid;
    logic [IO_W-1:0] fifo_data;
    logic            fifo_pop;
    logic            go;
    logic            rd_cycle;

    // Write data is staged here so the caller may run ahead of the slow bus.
    nbh_fifo #(.W(IO_W), .DEPTH(DEPTH)) u_fifo (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (wr_valid_i),
        .in_data_i   (wr_data_i),
        .in_ready_o  (wr_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    always_comb begin
        next_r          = r;
        next_r.done     = 1'b0;
        next_r.rd_valid = 1'b0;
        fifo_pop        = 1'b0;
        rd_cycle        = (r.st == ST_DATA) && !r.wr;
        // A busy target is only addressed with a status read.
        go = (r.st == ST_CMD) ? (rb_n_i || is_status(r.cmd)) :
             ((r.st == ST_DATA) && r.wr) ? fifo_valid : 1'b1;
        unique case (r.st)
            ST_IDLE: begin
                next_r.ce_n = 1'b1;
                // Write protect only moves between sequences.
                next_r.wp_n = !wp_en_i;
                if (req_valid_i && r.req_ready) begin
                    next_r.cmd       = req_cmd_i;
                    next_r.naddr     = req_naddr_i;
                    next_r.col       = req_col_i;
                    next_r.page      = req_page_i;
                    next_r.blk       = req_block_i;
                    next_r.wr        = req_write_i;
                    next_r.ndata     = req_ndata_i;
                    next_r.cmd2_en   = req_cmd2_en_i;
                    next_r.cmd2      = req_cmd2_i;
                    next_r.waitr     = req_wait_i;
                    next_r.req_ready = 1'b0;
                    next_r.busy      = 1'b1;
                    next_r.st        = ST_CMD;
                    next_r.ph        = PH_SETUP;
                    next_r.cnt       = SETUP_LD;
                end
            end
            ST_CMD, ST_ADDR, ST_DATA, ST_CMD2: begin
                next_r.ce_n = 1'b0;
                unique case (r.ph)
                    PH_SETUP: begin
                        next_r.cle = (r.st == ST_CMD) || (r.st == ST_CMD2);
                        next_r.ale = (r.st == ST_ADDR);
                        next_r.oe  = !rd_cycle;
                        if (r.st == ST_CMD) begin
                            next_r.io = {8'h00, r.cmd};
                        end else if (r.st == ST_CMD2) begin
                            next_r.io = {8'h00, r.cmd2};
                        end else if (r.st == ST_ADDR) begin
                            next_r.io = {8'h00,
                                addr_byte(r.aidx, r.col, r.page, r.blk)};
                        end
                        if (r.cnt != 8'h00) begin
                            next_r.cnt = r.cnt - 8'h01;
                        end else if (go) begin
                            next_r.ph  = PH_LOW;
                            next_r.cnt = LOW_LD;
                            if (rd_cycle) begin
                                next_r.re_n = 1'b0;
                            end else begin
                                next_r.we_n = 1'b0;
                            end
                            if ((r.st == ST_DATA) && r.wr) begin
                                fifo_pop  = 1'b1;
                                next_r.io = WIDE ? fifo_data
                                                 : {8'h00, fifo_data[7:0]};
                            end
                        end
                    end
                    PH_LOW: begin
                        if (r.cnt != 8'h00) begin
                            next_r.cnt = r.cnt - 8'h01;
                        end else begin
                            next_r.we_n = 1'b1;
                            next_r.re_n = 1'b1;
                            next_r.ph   = PH_HIGH;
                            next_r.cnt  = HIGH_LD;
                            if (rd_cycle) begin
                                // Sampled just before the strobe rises, so slow
                                // read cycles see settled data.
                                next_r.rd_valid = 1'b1;
                                next_r.rd_data  = WIDE ? io_i : {8'h00, io_i[7:0]};
                            end
                        end
                    end
                    PH_HIGH: begin
                        if (r.cnt != 8'h00) begin
                            next_r.cnt = r.cnt - 8'h01;
                        end else begin
                            next_r.ph  = PH_SETUP;
                            next_r.cnt = SETUP_LD;
                            unique case (r.st)
                                ST_CMD: begin
                                    next_r.aidx = 3'h0;
                                    next_r.dcnt = '0;
                                    next_r.st   = pick(r.naddr != 3'h0, r.ndata != '0,
                                                       r.cmd2_en);
                                end
                                ST_ADDR: begin
                                    if (r.aidx == r.naddr - 3'h1) begin
                                        next_r.st = pick(1'b0, r.ndata != '0, r.cmd2_en);
                                    end else begin
                                        next_r.aidx = r.aidx + 3'h1;
                                    end
                                end
                                ST_DATA: begin
                                    if (r.dcnt == r.ndata - NDATA_W'(1)) begin
                                        next_r.st = pick(1'b0, 1'b0, r.cmd2_en);
                                    end else begin
                                        next_r.dcnt = r.dcnt + NDATA_W'(1);
                                    end
                                end
                                default: begin
                                    next_r.st = ST_FIN;
                                end
                            endcase
                        end
                    end
                    default: begin
                        next_r.ph  = PH_SETUP;
                        next_r.cnt = SETUP_LD;
                    end
                endcase
            end
            ST_FIN: begin
                // Releasing chip enable frees the bus while the die works on.
                next_r.ce_n = 1'b1;
                next_r.cle  = 1'b0;
                next_r.ale  = 1'b0;
                next_r.oe   = 1'b0;
                next_r.io   = '0;
                next_r.cnt  = WB_LD;
                if (r.waitr) begin
                    next_r.st = ST_WAITB;
                end else begin
                    next_r.st        = ST_IDLE;
                    next_r.done      = 1'b1;
                    next_r.busy      = 1'b0;
                    next_r.req_ready = 1'b1;
                end
            end
            ST_WAITB: begin
                // Ready/busy needs time to fall, so it is trusted only after the wait.
                if (r.cnt != 8'h00) begin
                    next_r.cnt = r.cnt - 8'h01;
                end else if (rb_n_i) begin
                    next_r.st        = ST_IDLE;
                    next_r.done      = 1'b1;
                    next_r.busy      = 1'b0;
                    next_r.req_ready = 1'b1;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r           <= '0;
            r.ce_n      <= 1'b1;
            r.we_n      <= 1'b1;
            r.re_n      <= 1'b1;
            r.req_ready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign req_ready_o     = r.req_ready;
    assign rd_valid_o      = r.rd_valid;
    assign rd_data_o       = r.rd_data;
    assign done_o          = r.done;
    assign busy_o          = r.busy;
    assign ce_n_o          = r.ce_n;
    assign cle_o           = r.cle;
    assign ale_o           = r.ale;
    assign we_n_o          = r.we_n;
    assign read_strobe_n_o = r.re_n;
    assign wp_n_o          = r.wp_n;
    assign io_o            = r.io;
    assign io_oe_o         = r.oe;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_we_fall;
        $fell(we_n_o);
    endsequence
    sequence s_we_pulse;
        !we_n_o [*3] ##1 we_n_o;
    endsequence
    sequence s_re_fall;
        $fell(read_strobe_n_o) && !cle_o && !ale_o && we_n_o && !ce_n_o;
    endsequence

    AST_NOT_BOTH_LATCH: assert property (!(cle_o && ale_o))
        else $error("command and address latch high together");
    AST_CMD_UPPER_ZERO: assert property (cle_o |-> io_o[15:8] == 8'h00)
        else $error("upper byte not zero in command cycle");
    AST_ADDR_UPPER_ZERO: assert property (ale_o |-> io_o[15:8] == 8'h00)
        else $error("upper byte not zero in address cycle");
    AST_CMD_PULSE: assert property (s_we_fall and cle_o |->
        (s_we_pulse and (cle_o && !ale_o && read_strobe_n_o && !ce_n_o) [*4]))
        else $error("command strobe malformed");
    AST_ADDR_PULSE: assert property (s_we_fall and ale_o |->
        (s_we_pulse and (ale_o && !cle_o && read_strobe_n_o && !ce_n_o) [*4]))
        else $error("address strobe malformed");
    AST_BUSY_CMD: assert property (s_we_fall and cle_o and !rb_n_i |->
        is_status(io_o[7:0]))
        else $error("non-status command issued while busy");
    AST_COL_MASK: assert property (s_we_fall and ale_o and r.aidx == 3'h1
        and io_o[3] |-> io_o[2:0] == 3'b000 && $past(io_o[7], 3) == 1'b0)
        else $error("column bits not cleared with bit 11 set");
    AST_READ_SAMPLE: assert property (s_re_fall |-> ##[3:4] rd_valid_o)
        else $error("read data not captured after read strobe");
    AST_STANDBY: assert property (done_o |-> ce_n_o && we_n_o && read_strobe_n_o)
        else $error("chip enable low after sequence end");
    AST_WP_STABLE: assert property (busy_o && $past(busy_o, 1) |-> $stable(wp_n_o))
        else $error("write protect moved inside a sequence");
endmodule

//--- testbench/nbh_dev_model.sv
// Behavioural NAND die seen from its bus pins, the far side of the host.
`timescale 1ns/1ns
module nbh_dev_model (
    input  wire logic        ce_n_i,
    input  wire logic        cle_i,
    input  wire logic        ale_i,
    input  wire logic        we_n_i,
    input  wire logic        read_strobe_n_i,
    input  wire logic        wp_n_i,
    input  wire logic        busy_i,
    input  wire logic [15:0] io_i,
    output logic [15:0]      io_o,
    output logic             rb_n_o
);
    logic [7:0]  cmds[$];
    logic [7:0]  addrs[$];
    logic [15:0] words[$];
    int          bad_hi = 0;
    int          nrd    = 0;
    assign rb_n_o = !busy_i;
    initial io_o = 16'h0000;
    // Both latches high, or chip enable high, latch nothing.
    always @(posedge we_n_i) begin
        if (!ce_n_i && read_strobe_n_i) begin
            if ((cle_i || ale_i) && io_i[15:8] !== 8'h00) begin
                bad_hi++;
            end
            if (cle_i && !ale_i && (!busy_i || io_i[7:0] == 8'h70 || io_i[7:0] == 8'h78)) begin
                cmds.push_back(io_i[7:0]);
            end else if (ale_i && !cle_i && (!busy_i || cmds[$] == 8'h78)) begin
                addrs.push_back(io_i[7:0]);
            end else if (!cle_i && !ale_i && !busy_i && wp_n_i) begin
                words.push_back(io_i);
            end
        end
    end
    // Status after a status command, else a counting pattern the bench can predict.
    always @(negedge read_strobe_n_i) begin
        if (!ce_n_i && !cle_i && !ale_i && we_n_i) begin
            nrd++;
            io_o <= (cmds[$] == 8'h70 || cmds[$] == 8'h78) ? {9'h000, !busy_i, 6'h00}
                                                          : 16'h5A00 + 16'(nrd);
        end
    end
    // A released bus must not look as if it still held the last word.
    always @(posedge read_strobe_n_i) io_o <= #2 ~io_o;
endmodule

//--- testbench/nbh_host_test.sv
// Self-checking bench of the NAND bus host against a behavioural die.
`timescale 1ns/1ns
module nbh_host_test;
    import nbh_pkg::*;
    logic        mclk_i = 0, rst_n_i = 0, req_valid = 0, wr = 0, c2en = 0, rwait = 0;
    logic        wr_valid = 0, wp_en = 0, dbusy = 0;
    logic [7:0]  req_cmd = 8'h00, cmd2 = 8'h10;
    logic [5:0]  page = 6'h2A;
    logic [10:0] blk = 11'h5C3;
    logic [11:0] col = 12'h8FF;
    logic [2:0]  naddr = 3'h0;
    logic [11:0] ndata = 12'h000;
    logic [15:0] wr_data = 16'h0000, rd_data, h_io, d_io, io_bus, x8_rd;
    logic        req_ready, wr_ready, rd_valid, done, busy, ce_n, cle, ale, we_n, rs_n;
    logic        wp_n, oe, rb_n;
    logic [15:0] rd_q[$];
    logic [7:0]  exp_a[5] = '{8'h7F, 8'h08, 8'hEA, 8'h70, 8'h01};
    int          err_total = 0;
    int          checks_done = 0;
    assign io_bus = oe ? h_io : d_io;
    always #2 mclk_i = ~mclk_i;
    always @(negedge mclk_i) if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    nbh_host #(.WIDE(1'b1), .DEPTH(32)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_cmd_i(req_cmd),
        .req_naddr_i(naddr), .req_col_i(col), .req_page_i(page), .req_block_i(blk),
        .req_write_i(wr), .req_ndata_i(ndata), .req_cmd2_en_i(c2en), .req_cmd2_i(cmd2),
        .req_wait_i(rwait), .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ready_o(wr_ready),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .done_o(done), .busy_o(busy),
        .wp_en_i(wp_en), .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n),
        .read_strobe_n_o(rs_n), .wp_n_o(wp_n), .io_o(h_io), .io_oe_o(oe), .io_i(io_bus),
        .rb_n_i(rb_n));
    nbh_dev_model i_dev (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
        .read_strobe_n_i(rs_n), .wp_n_i(wp_n), .busy_i(dbusy), .io_i(io_bus), .io_o(d_io),
        .rb_n_o(rb_n));
    // Byte-wide twin on the same pins, so the narrow read data path is exercised too.
    nbh_host #(.WIDE(1'b0)) i_x8 (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid), .req_ready_o(), .req_cmd_i(req_cmd),
        .req_naddr_i(naddr), .req_col_i(col), .req_page_i(page), .req_block_i(blk),
        .req_write_i(wr), .req_ndata_i(ndata), .req_cmd2_en_i(c2en), .req_cmd2_i(cmd2),
        .req_wait_i(rwait), .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ready_o(),
        .rd_valid_o(), .rd_data_o(x8_rd), .done_o(), .busy_o(),
        .wp_en_i(wp_en), .ce_n_o(), .cle_o(), .ale_o(), .we_n_o(),
        .read_strobe_n_o(), .wp_n_o(), .io_o(), .io_oe_o(), .io_i(io_bus), .rb_n_i(rb_n));
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One whole sequence; the wait is bounded so a hang ends the run.
    task automatic run(input logic [7:0] c, input logic [2:0] na, input logic w,
                       input logic [11:0] nd, input logic e2, input logic rw);
        int i;
        @(posedge mclk_i);
        #1;
        {req_cmd, naddr, wr, ndata, c2en, rwait} = {c, na, w, nd, e2, rw};
        req_valid = 1;
        @(posedge mclk_i);
        #1;
        req_valid = 0;
        for (i = 0; i < 4000 && done !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
        if (done !== 1'b1) begin
            err_total++;
            test_done();
        end
    endtask
    // Fill the buffer until it refuses, then drain it in one program sequence.
    task automatic s_write();
        int i;
        int n;
        n = 0;
        for (i = 0; i < 40; i++) begin
            @(posedge mclk_i);
            #1;
            if (wr_ready !== 1'b1) break;
            wr_valid = 1;
            wr_data = 16'h1000 + 16'(n);
            n++;
        end
        wr_valid = 0;
        check("fifo fill", 16'h0021, 16'(n));
        run(8'h80, 3'h5, 1'b1, 12'h021, 1'b1, 1'b1);
        check("first cmd", 16'h0080, {8'h00, i_dev.cmds[0]});
        check("second cmd", 16'h0010, {8'h00, i_dev.cmds[1]});
        for (i = 0; i < 5; i++) begin
            check("addr byte", {8'h00, exp_a[i]}, {8'h00, i_dev.addrs[i]});
        end
        check("upper byte", 16'h0000, 16'(i_dev.bad_hi));
        check("word count", 16'h0021, 16'(i_dev.words.size()));
        check("first word", 16'h1000, i_dev.words[0]);
        check("last word", 16'h1020, i_dev.words[32]);
    endtask
    task automatic s_read();
        i_dev.nrd = 0;
        rd_q.delete();
        cmd2 = 8'h30;
        run(8'h00, 3'h5, 1'b0, 12'h003, 1'b1, 1'b0);
        check("read count", 16'h0003, 16'(rd_q.size()));
        check("read last", 16'h5A03, rd_q[2]);
        check("read confirm", 16'h0030, {8'h00, i_dev.cmds[3]});
        check("byte read", 16'h0003, x8_rd);
    endtask
    // Status goes through a busy die; a normal command waits for ready.
    task automatic s_busy();
        i_dev.cmds.delete();
        i_dev.addrs.delete();
        rd_q.delete();
        dbusy = 1;
        run(8'h70, 3'h0, 1'b0, 12'h001, 1'b0, 1'b0);
        check("busy status", 16'h0000, rd_q[0]);
        {col, page} = {12'h4A5, 6'h15};
        run(8'h78, 3'h3, 1'b0, 12'h001, 1'b0, 1'b0);
        check("die status", 16'h0000, rd_q[1]);
        check("busy addr", 16'h0003, 16'(i_dev.addrs.size()));
        check("open column", 16'h04A5, {i_dev.addrs[1], i_dev.addrs[0]});
        check("row low", 16'h00D5, {8'h00, i_dev.addrs[2]});
        fork
            run(8'h00, 3'h5, 1'b0, 12'h000, 1'b0, 1'b0);
            begin
                repeat (200) @(posedge mclk_i);
                #1;
                check("held cmd", 16'h0002, 16'(i_dev.cmds.size()));
                wp_en = 1;
                dbusy = 0;
            end
        join
        check("late cmd", 16'h0003, 16'(i_dev.cmds.size()));
        check("wp held", 16'h0001, {15'h0000, wp_n});
        repeat (3) @(posedge mclk_i);
        #1;
        check("write protect", 16'h0000, {15'h0000, wp_n});
    endtask
    initial begin
        repeat (20) @(posedge mclk_i);
        #1;
        rst_n_i = 1;
        s_write();
        s_read();
        s_busy();
        test_done();
    end
endmodule
